// [hw/rcog_top.sv]
/*
 * Reference clock output generator with an Avalon-MM register port.
 * Divides a selected source by twice an integer plus a fractional trim,
 * drives the result to the pin and to internal users, and stops it in
 * idle and sleep unless told to run.
 * Assumes source levels and power-mode inputs are synchronous to
 * CORE_CLK, and that sources run below half the core clock rate.
 */
// Added by the designer: the Avalon-MM register port and the placing of the registers.
// Operation
// - Generator runs only while enable bit set
// - Idle-run bit chooses running or stopped in Idle
// - Pin driven only while output-enable set
// - Sleep-run bit chooses running or stopped in Sleep
// - Switch request set by software, cleared when done
// - Active bit shows clock running, zero once stopped
// - Select codes pick eight sources, rest reserved
// - Integer divider divides source by twice value
// - Divider zero passes source clock through undivided
// - Trim adds value/512 to each half period
// - Unimplemented bits always read as zero
`timescale 1ns/100ps
module rcog_top
	import rcog_pkg::*;
#(
	parameter int DIV_W  = RCOG_DIV_W,
	parameter int TRIM_W = RCOG_TRIM_W
) (
	input  wire logic                   CORE_CLK,
	input  wire logic                   RSTN,
	input  wire logic [RCOG_ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic                   AVS_READ,
	input  wire logic                   AVS_WRITE,
	input  wire logic [31:0]            AVS_WRITEDATA,
	input  wire logic [3:0]             AVS_BYTEENABLE,
	output logic [31:0]                 AVS_READDATA,
	output logic                        AVS_WAITREQUEST,
	input  wire rcog_src_t              SRC_CLOCKS,
	input  wire logic                   IDLE_MODE,
	input  wire logic                   SLEEP_MODE,
	output logic                        REFCLK_OUTPUT_PIN,
	output logic                        REFCLK_INTERNAL,
	output logic                        REFCLK_ACTIVE
);

	// ************************************************************
	// Declarations
	// ************************************************************
	rcog_ctrl_t          ctrl_q;
	logic                sw_q;
	logic [DIV_W-1:0]    div_q;
	logic [TRIM_W-1:0]   trim_q;
	logic [DIV_W-1:0]    div_act_q;
	logic [TRIM_W-1:0]   trim_act_q;
	logic [TRIM_W-1:0]   acc_q;
	logic [DIV_W:0]      cnt_q;
	logic [DIV_W:0]      len_q;
	logic                gen_q;
	rcog_state_t         st_q;
	rcog_state_t         st_d;
	logic                wait_q;
	logic [31:0]         rdata_q;
	logic                pin_q;
	logic                int_q;
	logic                act_q;
	logic                src_lvl;
	logic                src_rise;
	logic                run_req;
	logic                bypass;
	logic                boundary;
	logic                apply_ok;
	logic                take;
	logic                wr_hit;
	logic                rd_take;
	logic [TRIM_W:0]     acc_sum;
	logic [15:0]         ctrl_m;
	logic [15:0]         div_m;
	logic [15:0]         trim_m;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Merge a 16-bit register with the two low write lanes
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction

	// Half-period length from divider and trim carry
	function automatic logic [DIV_W:0] half_len(input logic [DIV_W-1:0] d,
		input logic c);
		return {1'b0, d} + {{DIV_W{1'b0}}, c};
	endfunction

	// ************************************************************
	// Source selection
	// ************************************************************
	rcog_src_mux u_src (
		.clk  (CORE_CLK),
		.rst_n(RSTN),
		.src  (SRC_CLOCKS),
		.sel  (ctrl_q.refclk_source_select),
		.lvl  (src_lvl),
		.rise (src_rise)
	);

	// ************************************************************
	// Avalon-MM slave
	// ************************************************************
	// One wait cycle on every access keeps read data registered
	assign take    = (AVS_READ | AVS_WRITE) & wait_q;
	assign wr_hit  = AVS_WRITE & ~wait_q;
	assign rd_take = AVS_READ & wait_q;

	// Wait request drops for exactly one edge per access
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN)
			wait_q <= 1'b1;
		else
			wait_q <= ~take;
	end

	// Read mux; unimplemented and unmapped bits read zero
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			case (AVS_ADDRESS)
				RCOG_OFF_CTRL: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[RCOG_B_EN]        <= ctrl_q.refclk_generator_enable;
					rdata_q[RCOG_B_RUN_IDLE]  <= ctrl_q.refclk_run_in_idle;
					rdata_q[RCOG_B_PIN_OE]    <= ctrl_q.refclk_pin_output_enable;
					rdata_q[RCOG_B_RUN_SLEEP] <= ctrl_q.refclk_run_in_sleep;
					rdata_q[RCOG_B_SWITCH]    <= sw_q;
					rdata_q[RCOG_B_ACTIVE]    <= act_q;
					rdata_q[RCOG_SEL_LSB +: RCOG_SEL_W] <=
						ctrl_q.refclk_source_select;
				end
				RCOG_OFF_DIV:
					rdata_q <= {17'h00000, div_q};
				RCOG_OFF_TRIM:
					rdata_q <= {16'h0000, trim_q, 7'h00};
				default:
					rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Control fields; changes while active are the user's hazard
	assign ctrl_m = merge16({ctrl_q.refclk_generator_enable, 1'b0,
		ctrl_q.refclk_run_in_idle, ctrl_q.refclk_pin_output_enable,
		ctrl_q.refclk_run_in_sleep, 7'h00,
		ctrl_q.refclk_source_select}, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign div_m  = merge16({1'b0, div_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign trim_m = merge16({trim_q, 7'h00}, AVS_WRITEDATA, AVS_BYTEENABLE);

	always_ff @(posedge CORE_CLK) begin : ctrl_reg
		if (!RSTN) begin
			ctrl_q <= '{1'b0, 1'b0, 1'b0, 1'b0, RCOG_SEL_RST};
		end else if (wr_hit && AVS_ADDRESS == RCOG_OFF_CTRL) begin
			ctrl_q.refclk_generator_enable  <= ctrl_m[RCOG_B_EN];
			ctrl_q.refclk_run_in_idle       <= ctrl_m[RCOG_B_RUN_IDLE];
			ctrl_q.refclk_pin_output_enable <= ctrl_m[RCOG_B_PIN_OE];
			ctrl_q.refclk_run_in_sleep      <= ctrl_m[RCOG_B_RUN_SLEEP];
			ctrl_q.refclk_source_select     <=
				ctrl_m[RCOG_SEL_LSB +: RCOG_SEL_W];
		end
	end

	// Divider and trim staging values
	always_ff @(posedge CORE_CLK) begin : cfg_reg
		if (!RSTN) begin
			div_q  <= RCOG_DIV_RST;
			trim_q <= RCOG_TRIM_RST;
		end else if (wr_hit && AVS_ADDRESS == RCOG_OFF_DIV) begin
			div_q <= div_m[DIV_W-1:0];
		end else if (wr_hit && AVS_ADDRESS == RCOG_OFF_TRIM) begin
			trim_q <= trim_m[RCOG_TRIM_LSB +: TRIM_W];
		end
	end

	// Switch request: software write checked before hardware clear, so set wins
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN)
			sw_q <= 1'b0;
		else if (wr_hit && AVS_ADDRESS == RCOG_OFF_CTRL
			&& AVS_BYTEENABLE[1])
			sw_q <= AVS_WRITEDATA[RCOG_B_SWITCH];
		else if (apply_ok)
			sw_q <= 1'b0;
	end

	// ************************************************************
	// Run conditions
	// ************************************************************
	assign run_req = ctrl_q.refclk_generator_enable
		& (~IDLE_MODE | ctrl_q.refclk_run_in_idle)
		& (~SLEEP_MODE | ctrl_q.refclk_run_in_sleep);
	assign bypass   = (div_act_q == '0);
	assign boundary = src_rise && (cnt_q == len_q - {{DIV_W{1'b0}}, 1'b1});
	// A change lands only where the output has just settled
	assign apply_ok = sw_q && (st_q == RCOG_ST_STOP
		|| (bypass ? (!gen_q && !src_lvl) : boundary));
	assign acc_sum  = {1'b0, acc_q} + {1'b0, trim_act_q};

	// ************************************************************
	// Generator state machine
	// ************************************************************
	// Draining finishes the high phase so the clock never ends in a runt
	always_comb begin
		st_d = st_q;
		case (st_q)
			RCOG_ST_STOP:
				if (run_req)
					st_d = RCOG_ST_RUN;
			RCOG_ST_RUN:
				if (!run_req)
					st_d = RCOG_ST_DRAIN;
			RCOG_ST_DRAIN:
				if (run_req)
					st_d = RCOG_ST_RUN;
				else if (!gen_q)
					st_d = RCOG_ST_STOP;
			default:
				st_d = RCOG_ST_STOP;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN)
			st_q <= RCOG_ST_STOP;
		else
			st_q <= st_d;
	end

	// Active divider and trim, loaded only on a granted switch
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			div_act_q  <= RCOG_DIV_RST;
			trim_act_q <= RCOG_TRIM_RST;
		end else if (apply_ok) begin
			div_act_q  <= div_q;
			trim_act_q <= trim_q;
		end
	end

	// Half-period counter, length and fraction accumulator
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			cnt_q <= '0;
			len_q <= '0;
			acc_q <= '0;
		end else if (st_q == RCOG_ST_STOP || apply_ok) begin
			cnt_q <= '0;
			len_q <= half_len(apply_ok ? div_q : div_act_q, 1'b0);
			acc_q <= '0;
		end else if (boundary) begin
			cnt_q <= '0;
			len_q <= half_len(div_act_q, acc_sum[TRIM_W]);
			acc_q <= acc_sum[TRIM_W-1:0];
		end else if (src_rise) begin
			cnt_q <= cnt_q + {{DIV_W{1'b0}}, 1'b1};
		end
	end

	// Output level: follows the source in bypass, toggles otherwise
	// Held low on the edge into stop, else a last edge leaves a runt
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN)
			gen_q <= 1'b0;
		else if (st_q == RCOG_ST_STOP || st_d == RCOG_ST_STOP)
			gen_q <= 1'b0;
		else if (bypass)
			gen_q <= src_lvl;
		else if (boundary)
			gen_q <= ~gen_q;
	end

	// ************************************************************
	// Outputs, all registered
	// ************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			pin_q <= 1'b0;
			int_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			pin_q <= gen_q & ctrl_q.refclk_pin_output_enable;
			int_q <= gen_q;
			act_q <= (st_d != RCOG_ST_STOP);
		end
	end

	assign REFCLK_OUTPUT_PIN = pin_q;
	assign REFCLK_INTERNAL   = int_q;
	assign REFCLK_ACTIVE     = act_q;
	assign AVS_READDATA      = rdata_q;
	assign AVS_WAITREQUEST   = wait_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);

	sequence s_off_and_stopped;
		!run_req && st_q == RCOG_ST_STOP;
	endsequence

	sequence s_ctrl_read;
		AVS_READ && !wait_q && $past(AVS_ADDRESS) == RCOG_OFF_CTRL;
	endsequence

	a_stays_stopped: assert property (
		s_off_and_stopped ##1 !run_req |-> !gen_q && !act_q)
		else $error("generator ran while not requested");

	a_pin_gated: assert property (
		!ctrl_q.refclk_pin_output_enable |=> !REFCLK_OUTPUT_PIN)
		else $error("pin driven with output disabled");

	a_switch_done: assert property (
		sw_q && st_q == RCOG_ST_STOP && !wr_hit |=> !sw_q)
		else $error("switch request not cleared when stopped");

	a_active_low: assert property (
		!act_q ##1 !act_q |-> !int_q)
		else $error("clock running while status reads stopped");

	a_toggle_edge: assert property (
		!bypass && $changed(gen_q) && $past(st_q) != RCOG_ST_STOP
		|-> $past(boundary))
		else $error("divided output moved off a half-period end");

	a_bypass_follow: assert property (
		st_q != RCOG_ST_STOP && bypass ##1 st_q != RCOG_ST_STOP
		|-> gen_q == $past(src_lvl))
		else $error("bypass output does not follow source");

	a_read_zero: assert property (
		s_ctrl_read |-> AVS_READDATA[31:16] == 16'h0000
		&& AVS_READDATA[14] == 1'b0 && AVS_READDATA[10] == 1'b0
		&& AVS_READDATA[7:4] == 4'h0)
		else $error("unimplemented control bits read nonzero");

	a_div_switch: assert property (
		$changed(div_act_q) |-> $past(apply_ok))
		else $error("divider changed outside a granted switch");

	a_one_wait: assert property (
		(AVS_READ || AVS_WRITE) && wait_q |=> !wait_q ##1 wait_q)
		else $error("bus answer not exactly one cycle");

endmodule

// [common/rcog_pkg.sv]
/*
 * Shared constants and types of the reference clock output generator:
 * register offsets, field positions, reset values and source codes.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package rcog_pkg;

	// ************************************************************
	// Register map, byte addresses of aligned 32-bit words
	// ************************************************************
	localparam int          RCOG_ADDR_W      = 4;
	localparam logic [3:0]  RCOG_OFF_CTRL    = 4'h0;
	localparam logic [3:0]  RCOG_OFF_DIV     = 4'h4;
	localparam logic [3:0]  RCOG_OFF_TRIM    = 4'h8;

	// ************************************************************
	// Field positions of the control-low and trim registers
	// ************************************************************
	localparam int          RCOG_B_EN        = 15;
	localparam int          RCOG_B_RUN_IDLE  = 13;
	localparam int          RCOG_B_PIN_OE    = 12;
	localparam int          RCOG_B_RUN_SLEEP = 11;
	localparam int          RCOG_B_SWITCH    = 9;
	localparam int          RCOG_B_ACTIVE    = 8;
	localparam int          RCOG_SEL_LSB     = 0;
	localparam int          RCOG_TRIM_LSB    = 7;

	// ************************************************************
	// Field widths and reset values
	// ************************************************************
	localparam int          RCOG_DIV_W       = 15;
	localparam int          RCOG_TRIM_W      = 9;
	localparam int          RCOG_SEL_W       = 4;
	localparam logic [14:0] RCOG_DIV_RST     = 15'h0000;
	localparam logic [8:0]  RCOG_TRIM_RST    = 9'h000;
	localparam logic [3:0]  RCOG_SEL_RST     = 4'h0;

	// ************************************************************
	// Source select codes; 4'h8 and above select no clock
	// ************************************************************
	localparam logic [3:0]  RCOG_SRC_SYS     = 4'h0;
	localparam logic [3:0]  RCOG_SRC_PERIPH  = 4'h1;
	localparam logic [3:0]  RCOG_SRC_POSC    = 4'h2;
	localparam logic [3:0]  RCOG_SRC_FAST_RC = 4'h3;
	localparam logic [3:0]  RCOG_SRC_LOWP_RC = 4'h4;
	localparam logic [3:0]  RCOG_SRC_BKUP_RC = 4'h5;
	localparam logic [3:0]  RCOG_SRC_VCO4    = 4'h6;
	localparam logic [3:0]  RCOG_SRC_PIN     = 4'h7;

	// Source clock levels, sampled on the core clock
	typedef struct packed {
		logic refclk_input_pin;
		logic vco_div4_clock;
		logic backup_fast_rc_clock;
		logic low_power_rc_clock;
		logic fast_rc_clock;
		logic primary_osc_clock;
		logic peripheral_clock;
		logic system_clock;
	} rcog_src_t;

	// Software configuration of the generator
	typedef struct packed {
		logic       refclk_generator_enable;
		logic       refclk_run_in_idle;
		logic       refclk_pin_output_enable;
		logic       refclk_run_in_sleep;
		logic [3:0] refclk_source_select;
	} rcog_ctrl_t;

	// Generator states
	typedef enum logic [1:0] {
		RCOG_ST_STOP  = 2'b00,
		RCOG_ST_RUN   = 2'b01,
		RCOG_ST_DRAIN = 2'b10
	} rcog_state_t;

endpackage

// [hw/rcog_src_mux.sv]
/*
 * Source selector of the reference clock generator: picks one source
 * level, registers it and flags its rising edges.
 * Assumes source levels are synchronous to the core clock and slower
 * than half of it.
 */
`timescale 1ns/100ps
module rcog_src_mux
	import rcog_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire rcog_src_t   src,
	input  wire logic [3:0]  sel,
	output logic             lvl,
	output logic             rise
);
	logic lvl_q;
	logic prv_q;
	logic pick;

	// ************************************************************
	// Selection
	// ************************************************************
	// Reserved codes give a quiet line, never a stale source
	always_comb begin
		case (sel)
			RCOG_SRC_SYS:    pick = src.system_clock;
			RCOG_SRC_PERIPH: pick = src.peripheral_clock;
			RCOG_SRC_POSC:   pick = src.primary_osc_clock;
			RCOG_SRC_FAST_RC: pick = src.fast_rc_clock;
			RCOG_SRC_LOWP_RC: pick = src.low_power_rc_clock;
			RCOG_SRC_BKUP_RC: pick = src.backup_fast_rc_clock;
			RCOG_SRC_VCO4:   pick = src.vco_div4_clock;
			RCOG_SRC_PIN:    pick = src.refclk_input_pin;
			default:         pick = 1'b0;
		endcase
	end

	// Level and previous level for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lvl_q <= 1'b0;
			prv_q <= 1'b0;
		end else begin
			lvl_q <= pick;
			prv_q <= lvl_q;
		end
	end

	assign lvl  = lvl_q;
	assign rise = lvl_q & ~prv_q;

	a_reserved_quiet: assert property (
		@(posedge clk) disable iff (!rst_n)
		sel[3] ##1 sel[3] |-> !lvl_q)
		else $error("reserved source code passed a clock");

endmodule

// [sim/rcog_pin_mon.sv]
/*
 * Far-side observer of the reference clock pin: counts edges and
 * measures high, low and shortest half periods in core cycles.
 * Assumes the pin is sampled on the core clock.
 */
`timescale 1ns/100ps
module rcog_pin_mon (
	input  wire logic        clk,
	input  wire logic        clr,
	input  wire logic        pin,
	output logic [15:0]      hi,
	output logic [15:0]      lo,
	output logic [15:0]      mn,
	output logic [15:0]      edges
);
	logic [15:0] run_q;
	logic        prev_q;
	logic        seen_q;

	// ************************************************************
	// Half-period measurement
	// ************************************************************
	// First edge after clear only starts a run: the run before it is partial
	always_ff @(posedge clk) begin
		prev_q <= pin;
		if (clr) begin
			hi <= 16'h0000;
			lo <= 16'h0000;
			mn <= 16'hffff;
			edges <= 16'h0000;
			run_q <= 16'h0000;
			seen_q <= 1'b0;
		end else if (pin != prev_q) begin
			edges <= edges + 16'h0001;
			seen_q <= 1'b1;
			run_q <= 16'h0001;
			if (seen_q && prev_q)
				hi <= run_q;
			if (seen_q && !prev_q)
				lo <= run_q;
			if (seen_q && run_q < mn)
				mn <= run_q;
		end else begin
			run_q <= run_q + 16'h0001;
		end
	end
endmodule

// [sim/rcog_tb_top.sv]
/*
 * Self-checking bench of the reference clock generator: register
 * access over Avalon-MM, source selection, division, trim, gating.
 * Assumes source i toggles every 2+i core cycles.
 */
`timescale 1ns/100ps
module rcog_tb_top
	import rcog_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [3:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic [7:0]  src;
	logic        idle;
	logic        sleep;
	logic        pin;
	logic        intl;
	logic        act;
	logic        clr;
	logic [15:0] hi;
	logic [15:0] lo;
	logic [15:0] mn;
	logic [15:0] edges;
	logic [31:0] q;
	logic [3:0]  be;
	logic [15:0] cur;
	int          hcnt[8];
	int          n_fail;
	int          checks_done;

	rcog_top dut (.CORE_CLK(clk), .RSTN(rst_n), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .SRC_CLOCKS(rcog_src_t'(src)),
		.IDLE_MODE(idle), .SLEEP_MODE(sleep),
		.REFCLK_OUTPUT_PIN(pin), .REFCLK_INTERNAL(intl),
		.REFCLK_ACTIVE(act));
	rcog_pin_mon mon (.clk(clk), .clr(clr), .pin(pin), .hi(hi),
		.lo(lo), .mn(mn), .edges(edges));

	// Core clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Sources of distinct rates so a wrong select shows in the period
	always_ff @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			if (!rst_n) begin
				hcnt[i] <= 0;
				src[i] <= 1'b0;
			end else if (hcnt[i] >= 1 + i) begin
				hcnt[i] <= 0;
				src[i] <= ~src[i];
			end else begin
				hcnt[i] <= hcnt[i] + 1;
			end
		end
	end

	// ************************************************************
	// Bus and check tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [15:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0);
		chk("bus answer edges", 32'd2, n);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Stop, wait for the clock to halt, then reconfigure
	task automatic cfg(input logic [15:0] c);
		int n;
		// Only the enable drops, so the source never moves while active
		bus(1'b1, RCOG_OFF_CTRL, cur & 16'h7fff);
		for (n = 0; n < 200 && act !== 1'b0; n++)
			@(posedge clk);
		chk("stopped before change", 32'h0, act);
		bus(1'b1, RCOG_OFF_CTRL, c);
		cur = c;
	endtask

	// Load divider and trim, request the switch, wait for the clear
	task automatic apply(input logic [15:0] base, input logic [15:0] d,
		input logic [15:0] t);
		int n;
		bus(1'b1, RCOG_OFF_DIV, d);
		bus(1'b1, RCOG_OFF_TRIM, t);
		bus(1'b1, RCOG_OFF_CTRL, base | 16'h0200);
		n = 0;
		do begin
			bus(1'b0, RCOG_OFF_CTRL, 16'h0000);
			n++;
		end while (q[9] !== 1'b0 && n < 200);
		chk("switch bit", 32'h0, q[9]);
	endtask

	task automatic settle(input int n);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog, about five times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{rst_n, addr, rd, wr, wdata, idle, sleep, clr} = '0;
		be = 4'hf;
		cur = 16'h0000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, unimplemented bits, unmapped word
		for (int a = 0; a < 3; a++) begin
			bus(1'b0, 4'(4 * a), 16'h0000);
			chk("reset value", 32'h0, q);
		end
		bus(1'b1, RCOG_OFF_CTRL, 16'h747f);
		bus(1'b0, RCOG_OFF_CTRL, 16'h0000);
		chk("ctrl bits", 32'h300f, q);
		bus(1'b1, RCOG_OFF_DIV, 16'hffff);
		bus(1'b0, RCOG_OFF_DIV, 16'h0000);
		chk("div bits", 32'h7fff, q);
		// Low lane alone leaves the high byte as it was
		be <= 4'h1;
		bus(1'b1, RCOG_OFF_DIV, 16'h0000);
		be <= 4'hf;
		bus(1'b0, RCOG_OFF_DIV, 16'h0000);
		chk("div low lane", 32'h7f00, q);
		bus(1'b1, RCOG_OFF_TRIM, 16'hffff);
		bus(1'b0, RCOG_OFF_TRIM, 16'h0000);
		chk("trim bits", 32'hff80, q);
		bus(1'b0, 4'hc, 16'h0000);
		chk("unmapped", 32'h0, q);
		bus(1'b1, RCOG_OFF_CTRL, 16'h0000);
		$display("test registers done");
		// Every source code at divide by four, reserved code silent
		apply(16'h0000, 16'h0002, 16'h0000);
		for (int s = 0; s < 9; s++) begin
			cfg(16'h9000 | 16'(s));
			settle(250);
			if (s < 8) begin
				chk("high half", 8 + 4 * s, hi);
				chk("low half", 8 + 4 * s, lo);
				chk("active", 32'h1, act);
			end else begin
				chk("reserved edges", 32'h0, edges);
			end
		end
		$display("test sources done");
		// Pin gated off while the generator runs, then stopped
		cfg(16'h8000);
		settle(100);
		chk("gated pin edges", 32'h0, edges);
		bus(1'b0, RCOG_OFF_CTRL, 16'h0000);
		chk("ctrl active", 32'h8100, q);
		cfg(16'h0000);
		bus(1'b0, RCOG_OFF_CTRL, 16'h0000);
		chk("ctrl stopped", 32'h0, q);
		settle(60);
		chk("internal low", 32'h0, intl);
		$display("test pin gate done");
		// Idle then sleep: stop when not told to run, run when told
		for (int m = 0; m < 2; m++) begin
			cfg(16'h9000);
			idle <= (m == 0);
			sleep <= (m == 1);
			// Let the high phase in flight finish before counting
			repeat (20) @(posedge clk);
			settle(100);
			chk("stopped act", 32'h0, act);
			chk("stopped edges", 32'h0, edges);
			cfg(m == 0 ? 16'hb000 : 16'h9800);
			settle(100);
			chk("run act", 32'h1, act);
			chk("run half", 32'h8, hi);
			idle <= 1'b0;
			sleep <= 1'b0;
		end
		$display("test low power done");
		// Bypass follows the source
		cfg(16'h0000);
		apply(16'h0000, 16'h0000, 16'h0000);
		cfg(16'h9001);
		settle(60);
		chk("bypass high", 32'h3, hi);
		chk("bypass low", 32'h3, lo);
		// Half trim: halves of one and two source periods alternate
		cfg(16'h0000);
		apply(16'h0000, 16'h0001, 16'h8000);
		cfg(16'h9000);
		settle(150);
		chk("trim period", 32'hc, hi + lo);
		chk("trim short half", 32'h4, mn);
		$display("test bypass trim done");
		// Divider change while running leaves no runt half
		cfg(16'h0000);
		apply(16'h0000, 16'h0002, 16'h0000);
		cfg(16'h9000);
		settle(60);
		apply(16'h9000, 16'h0001, 16'h0000);
		repeat (60) @(posedge clk);
		chk("no runt", 32'h4, mn);
		chk("new half", 32'h4, hi);
		$display("test switch done");
		tally_and_finish();
	end
endmodule
